// File: smrd_top.sv
// Functional notes
// - MRS with BA=1 loads extended register one
// - A12 set disconnects all data outputs
// - strobe enable turns mask pin into termination, but with A12 set termination stays off while the mask still follows strobe enable
// - termination strobe never drives read strobe
// - MRS with BA=2 loads register two
// - partial self-refresh loses data outside range
// - A5..A3 give whole-cycle cas write latency
// - write latency is additive plus cas write
// - read latency is additive plus cas latency
// - A10..A9 select write-time termination
// - write termination applies without nominal termination
// - write leveling disables dynamic termination
// - bit seven doubles self-refresh rate
// - MRS with BA=3 loads register three
// - multi-purpose register off ignores location bits
`timescale 1ns/1ps
`include "smrd_defines.svh"
module smrd_top
  import smrd_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic CS_N_IN,
  input wire logic RAS_N_IN,
  input wire logic CAS_N_IN,
  input wire logic WE_N_IN,
  input wire logic [2:0] BA_IN,
  input wire logic [15:0] ADDR_IN,
  input wire logic [3:0] CAS_LATENCY_IN,
  input wire logic WRITE_ACTIVE_IN,
  input wire logic SELF_REFRESH_IN,
  input wire logic [1:0] RD_IDX_IN,
  output logic [15:0] RD_DATA_OUT,
  output logic OUTPUTS_OFF_OUT,
  output logic STROBE_TERM_EN_OUT,
  output logic WRITE_MASK_EN_OUT,
  output logic STROBE_COMP_USED_OUT,
  output logic READ_STROBE_EN_OUT,
  output logic WRITE_LEVELING_OUT,
  output logic [2:0] PARTIAL_ARRAY_SELF_REFRESH_OUT,
  output logic RETAIN_ALL_OUT,
  output logic [3:0] CAS_WRITE_LATENCY_OUT,
  output logic [4:0] WRITE_LATENCY_OUT,
  output logic [4:0] READ_LATENCY_OUT,
  output logic [1:0] RTT_WR_OUT,
  output logic [2:0] RTT_NOM_OUT,
  output logic [2:0] ACTIVE_RTT_OUT,
  output logic DYN_ODT_EN_OUT,
  output logic SR_RATE_2X_OUT,
  output logic MPR_EN_OUT,
  output logic [1:0] MPR_LOC_OUT
);
  logic rst_s1_q, rst_s2_q;
  logic [8:0] pin_s1_q, pin_s2_q;
  logic [15:0] addr_s1_q, addr_s2_q;
  logic [15:0] mr1_q, mr2_q, mr3_q;
  logic [1:0] mr1_idx;
  wire rst_n = rst_s2_q;

  // reset released through two stages
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // command pins are external; synchronise before decoding
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 9'h1f8;
      pin_s2_q <= 9'h1f8;
      addr_s1_q <= 16'h0000;
      addr_s2_q <= 16'h0000;
    end else begin
      pin_s1_q <= {CS_N_IN, RAS_N_IN, CAS_N_IN, WE_N_IN, 2'h0, BA_IN};
      pin_s2_q <= pin_s1_q;
      addr_s1_q <= ADDR_IN;
      addr_s2_q <= addr_s1_q;
    end
  end

  function automatic logic [4:0] smrd_add_lat(input logic [4:0] al, input logic [3:0] lat);
    smrd_add_lat = al + {1'b0, lat};
  endfunction

  // synchronised pins carry a mode register set aimed at one bank
  function automatic logic smrd_bank_hit(input logic [8:0] pins, input logic [2:0] ba);
    smrd_bank_hit = (pins[8:5] == 4'h0) && (pins[2:0] == ba);
  endfunction

  wire mrs_cmd = (pin_s2_q[8:5] == 4'h0);
  wire mrs_mr1 = smrd_bank_hit(pin_s2_q, `SMRD_BA_MR1);
  wire mrs_mr2 = smrd_bank_hit(pin_s2_q, `SMRD_BA_MR2);
  wire mrs_mr3 = smrd_bank_hit(pin_s2_q, `SMRD_BA_MR3);

  // each register only updates on its own command
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      mr1_q <= `SMRD_RST_MR;
      mr2_q <= `SMRD_RST_MR;
      mr3_q <= `SMRD_RST_MR;
    end else begin
      if (mrs_mr1) mr1_q <= addr_s2_q;
      if (mrs_mr2) mr2_q <= addr_s2_q;
      if (mrs_mr3) mr3_q <= addr_s2_q;
    end
  end

  // readback copy of the programmed words
  assign mr1_idx = pin_s2_q[1:0];
  smrd_regmem u_mem (
    .clk_in(REF_CLK_IN),
    .rst_n_in(rst_n),
    // banks 4..7 would alias words 0..3 and break readback
    .wr_en_in(mrs_cmd && !pin_s2_q[2]),
    .wr_idx_in(mr1_idx),
    .wr_data_in(addr_s2_q),
    .rd_idx_in(RD_IDX_IN),
    .rd_data_out(RD_DATA_OUT)
  );

  wire qoff = mr1_q[`SMRD_MR1_QOFF];
  wire tstrb = mr1_q[`SMRD_MR1_TSTRB];
  wire wlvl = mr1_q[`SMRD_MR1_WLVL];
  wire [1:0] al_code = mr1_q[`SMRD_MR1_AL_LO +: 2];
  wire [2:0] rtt_nom = {mr1_q[`SMRD_MR1_RTTNOM_A9], mr1_q[`SMRD_MR1_RTTNOM_A6],
                        mr1_q[`SMRD_MR1_RTTNOM_A2]};
  wire [3:0] cas_write_latency = `SMRD_CWL_BASE + {1'b0, mr2_q[`SMRD_MR2_CWL_LO +: 3]};
  wire [1:0] rtt_wr = mr2_q[`SMRD_MR2_RTTWR_LO +: 2];
  wire mpr_en = mr3_q[`SMRD_MR3_MPR_EN];
  smrd_al_type al_mode;
  assign al_mode = smrd_al_type'(al_code);
  // additive latency is zero, CL-1 or CL-2; reserved code treated as zero
  wire [4:0] al_cyc = (al_mode == SMRD_AL_CL1) ? {1'b0, CAS_LATENCY_IN} - 5'h01 :
                      (al_mode == SMRD_AL_CL2) ? {1'b0, CAS_LATENCY_IN} - 5'h02 : 5'h00;
  wire dyn_odt = (rtt_wr != 2'h0) && !wlvl;
  wire [2:0] act_rtt = (WRITE_ACTIVE_IN && dyn_odt) ? {1'b0, rtt_wr} : rtt_nom;

  // roles of the shared strobe pins; output disable overrides the strobe
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      OUTPUTS_OFF_OUT <= 1'b0;
      STROBE_TERM_EN_OUT <= 1'b0;
      WRITE_MASK_EN_OUT <= 1'b1;
      STROBE_COMP_USED_OUT <= 1'b0;
      READ_STROBE_EN_OUT <= 1'b1;
      WRITE_LEVELING_OUT <= 1'b0;
    end else begin
      OUTPUTS_OFF_OUT <= qoff;
      STROBE_TERM_EN_OUT <= tstrb && !qoff;
      WRITE_MASK_EN_OUT <= !tstrb;
      STROBE_COMP_USED_OUT <= tstrb;
      READ_STROBE_EN_OUT <= !qoff;
      WRITE_LEVELING_OUT <= wlvl;
    end
  end

  // refresh controls
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      PARTIAL_ARRAY_SELF_REFRESH_OUT <= 3'h0;
      RETAIN_ALL_OUT <= 1'b1;
      SR_RATE_2X_OUT <= 1'b0;
    end else begin
      PARTIAL_ARRAY_SELF_REFRESH_OUT <= mr2_q[`SMRD_MR2_PARTIAL_ARRAY_SELF_REFRESH_LO +: 3];
      // data outside range only at risk inside self-refresh
      RETAIN_ALL_OUT <= !(SELF_REFRESH_IN && (mr2_q[2:0] != 3'h0));
      SR_RATE_2X_OUT <= mr2_q[`SMRD_MR2_SRT];
    end
  end

  // read latency tracks the cas latency input live, write latency only through CL-1 or CL-2 additive latency; no command needed
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      CAS_WRITE_LATENCY_OUT <= `SMRD_CWL_BASE;
      WRITE_LATENCY_OUT <= 5'h00;
      READ_LATENCY_OUT <= 5'h00;
    end else begin
      CAS_WRITE_LATENCY_OUT <= cas_write_latency;
      WRITE_LATENCY_OUT <= smrd_add_lat(al_cyc, cas_write_latency);
      READ_LATENCY_OUT <= smrd_add_lat(al_cyc, CAS_LATENCY_IN);
    end
  end

  // termination; write-time value wins only while a write is active
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      RTT_WR_OUT <= 2'h0;
      RTT_NOM_OUT <= 3'h0;
      ACTIVE_RTT_OUT <= 3'h0;
      DYN_ODT_EN_OUT <= 1'b0;
    end else begin
      RTT_WR_OUT <= rtt_wr;
      RTT_NOM_OUT <= rtt_nom;
      ACTIVE_RTT_OUT <= act_rtt;
      DYN_ODT_EN_OUT <= dyn_odt;
    end
  end

  // location forced to zero so a disabled register shows no stale page
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      MPR_EN_OUT <= 1'b0;
      MPR_LOC_OUT <= 2'h0;
    end else begin
      MPR_EN_OUT <= mpr_en;
      MPR_LOC_OUT <= mpr_en ? mr3_q[`SMRD_MR3_MPR_LOC_LO +: 2] : 2'h0;
    end
  end
endmodule // smrd_top

// File: smrd_defines.svh
`ifndef SMRD_DEFINES_SVH
`define SMRD_DEFINES_SVH
// bank address selecting each mode register
`define SMRD_BA_MR1 3'h1
`define SMRD_BA_MR2 3'h2
`define SMRD_BA_MR3 3'h3
// first extended mode register fields
`define SMRD_MR1_AL_LO 3
`define SMRD_MR1_WLVL 7
`define SMRD_MR1_TSTRB 11
`define SMRD_MR1_QOFF 12
`define SMRD_MR1_RTTNOM_A2 2
`define SMRD_MR1_RTTNOM_A6 6
`define SMRD_MR1_RTTNOM_A9 9
// second mode register fields
`define SMRD_MR2_PARTIAL_ARRAY_SELF_REFRESH_LO 0
`define SMRD_MR2_CWL_LO 3
`define SMRD_MR2_SRT 7
`define SMRD_MR2_RTTWR_LO 9
// third mode register fields
`define SMRD_MR3_MPR_LOC_LO 0
`define SMRD_MR3_MPR_EN 2
// reset values
`define SMRD_RST_MR 16'h0000
// cas write latency code 0 means 5 cycles
`define SMRD_CWL_BASE 4'h5
`define SMRD_MEM_DEPTH 4
`endif

// File: smrd_pkg.sv
package smrd_pkg;
  typedef enum logic [1:0] {SMRD_AL_OFF, SMRD_AL_CL1, SMRD_AL_CL2, SMRD_AL_RSV} smrd_al_type;
endpackage

// File: smrd_regmem.sv
`timescale 1ns/1ps
`include "smrd_defines.svh"
module smrd_regmem (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic [1:0] wr_idx_in,
  input wire logic [15:0] wr_data_in,
  input wire logic [1:0] rd_idx_in,
  output logic [15:0] rd_data_out
);
  logic [15:0] mem_q [`SMRD_MEM_DEPTH];
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < `SMRD_MEM_DEPTH; i++) mem_q[i] <= `SMRD_RST_MR;
      rd_data_out <= `SMRD_RST_MR;
    end else begin
      if (wr_en_in) mem_q[wr_idx_in] <= wr_data_in;
      rd_data_out <= mem_q[rd_idx_in];
    end
  end
endmodule // smrd_regmem

// File: smrd_ctrl_model.sv
`timescale 1ns/1ps
module smrd_ctrl_model (
  input wire logic clk_in,
  output logic cs_n_out,
  output logic ras_n_out,
  output logic cas_n_out,
  output logic we_n_out,
  output logic [2:0] ba_out,
  output logic [15:0] addr_out
);
  initial begin
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hf;
    ba_out = 3'h0;
    addr_out = 16'h0000;
  end
  task automatic mrs(input logic [2:0] ba, input logic [15:0] a);
    @(posedge clk_in);
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= 4'h0;
    ba_out <= ba;
    addr_out <= a & (ba == 3'h2 ? 16'he6bf : ba == 3'h3 ? 16'he007 : 16'hffff);
    @(posedge clk_in);
    // deselected pins must not look like a held command
    cs_n_out <= 1'h1;
    ba_out <= ~ba;
    addr_out <= ~a;
    repeat (6) @(posedge clk_in);
  endtask
endmodule // smrd_ctrl_model

// File: smrd_top_properties.sv
`timescale 1ns/1ps
module smrd_top_checker (
  input wire logic REF_CLK_IN, RSTN_IN, CS_N_IN, RAS_N_IN, CAS_N_IN, WE_N_IN,
  input wire logic STROBE_TERM_EN_OUT, WRITE_MASK_EN_OUT, STROBE_COMP_USED_OUT,
  input wire logic OUTPUTS_OFF_OUT, READ_STROBE_EN_OUT, WRITE_LEVELING_OUT,
  input wire logic RETAIN_ALL_OUT, DYN_ODT_EN_OUT, SR_RATE_2X_OUT, MPR_EN_OUT,
  input wire logic [3:0] CAS_LATENCY_IN, CAS_WRITE_LATENCY_OUT,
  input wire logic [4:0] WRITE_LATENCY_OUT, READ_LATENCY_OUT,
  input wire logic [2:0] PARTIAL_ARRAY_SELF_REFRESH_OUT,
  input wire logic [1:0] RTT_WR_OUT, MPR_LOC_OUT
);
  logic [2:0] quiet_q;
  logic [2:0] quiet_d;
  wire cmd = !CS_N_IN && !RAS_N_IN && !CAS_N_IN && !WE_N_IN;
  // saturating count of edges since the last command on the pins
  assign quiet_d = cmd ? 3'h0 : (quiet_q == 3'h7 ? quiet_q : quiet_q + 3'h1);
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
    if (!RSTN_IN) quiet_q <= 3'h0;
    else quiet_q <= quiet_d;
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  property p_rstrb; READ_STROBE_EN_OUT != OUTPUTS_OFF_OUT; endproperty
  a_rstrb: assert property (p_rstrb) else $error("read strobe vs off");
  property p_mask; WRITE_MASK_EN_OUT != STROBE_COMP_USED_OUT; endproperty
  a_mask: assert property (p_mask) else $error("mask vs strobe");
  property p_cwl; CAS_WRITE_LATENCY_OUT >= 4'h5; endproperty
  a_cwl: assert property (p_cwl) else $error("cwl range");
  property p_al;
    quiet_q == 3'h7 |->
      WRITE_LATENCY_OUT - CAS_WRITE_LATENCY_OUT == READ_LATENCY_OUT - CAS_LATENCY_IN;
  endproperty
  a_al: assert property (p_al) else $error("latency sums");
  property p_dyn; DYN_ODT_EN_OUT |-> !WRITE_LEVELING_OUT && RTT_WR_OUT != 2'h0; endproperty
  a_dyn: assert property (p_dyn) else $error("dynamic odt");
  property p_mpr; !MPR_EN_OUT |-> MPR_LOC_OUT == 2'h0; endproperty
  a_mpr: assert property (p_mpr) else $error("mpr location");
  property p_retain; !RETAIN_ALL_OUT |-> PARTIAL_ARRAY_SELF_REFRESH_OUT != 3'h0; endproperty
  a_retain: assert property (p_retain) else $error("retain");
  property p_hold;
    quiet_q == 3'h7 |-> $stable({SR_RATE_2X_OUT, PARTIAL_ARRAY_SELF_REFRESH_OUT, RTT_WR_OUT, MPR_EN_OUT,
      CAS_WRITE_LATENCY_OUT, WRITE_LEVELING_OUT, OUTPUTS_OFF_OUT});
  endproperty
  a_hold: assert property (p_hold) else $error("field changed");
  c_term: cover property (STROBE_TERM_EN_OUT);
  c_wlvl: cover property (WRITE_LEVELING_OUT);
  c_mpr: cover property (MPR_EN_OUT);
endmodule // smrd_top_checker
bind smrd_top smrd_top_checker chk_i (.*);

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  logic REF_CLK_IN = 1'b0, RSTN_IN = 1'b0, WRITE_ACTIVE_IN = 1'b0, SELF_REFRESH_IN = 1'b0;
  logic [3:0] CAS_LATENCY_IN = 4'h9, CAS_WRITE_LATENCY_OUT;
  logic [1:0] RD_IDX_IN = 2'h0, RTT_WR_OUT, MPR_LOC_OUT;
  logic CS_N_IN, RAS_N_IN, CAS_N_IN, WE_N_IN, OUTPUTS_OFF_OUT, STROBE_TERM_EN_OUT;
  logic WRITE_MASK_EN_OUT, STROBE_COMP_USED_OUT, READ_STROBE_EN_OUT, WRITE_LEVELING_OUT;
  logic RETAIN_ALL_OUT, DYN_ODT_EN_OUT, SR_RATE_2X_OUT, MPR_EN_OUT;
  logic [2:0] BA_IN, PARTIAL_ARRAY_SELF_REFRESH_OUT, RTT_NOM_OUT, ACTIVE_RTT_OUT;
  logic [15:0] ADDR_IN, RD_DATA_OUT;
  logic [4:0] WRITE_LATENCY_OUT, READ_LATENCY_OUT;
  int mismatches = 0, n_compared = 0;
  smrd_top uut (.*);
  smrd_ctrl_model ctl (.clk_in(REF_CLK_IN), .cs_n_out(CS_N_IN), .ras_n_out(RAS_N_IN),
    .cas_n_out(CAS_N_IN), .we_n_out(WE_N_IN), .ba_out(BA_IN), .addr_out(ADDR_IN));
  always #12.5 REF_CLK_IN = ~REF_CLK_IN;
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run;
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge REF_CLK_IN);
  endtask
  task automatic t_strobe;
    chk("mask", 1, WRITE_MASK_EN_OUT);
    ctl.mrs(3'h1, 16'h0800);
    chk("term", 1, STROBE_TERM_EN_OUT);
    chk("mask", 0, WRITE_MASK_EN_OUT);
    chk("rstrb", 1, READ_STROBE_EN_OUT);
    chk("comp", 1, STROBE_COMP_USED_OUT);
    ctl.mrs(3'h1, 16'h1800);
    chk("off", 1, OUTPUTS_OFF_OUT);
    chk("rstrb", 0, READ_STROBE_EN_OUT);
  endtask
  task automatic t_latency;
    logic [4:0] al [4] = '{5'h0, 5'h8, 5'h7, 5'h0};
    for (int c = 0; c < 8; c++) begin
      ctl.mrs(3'h2, 16'(c) << 3);
      chk("cwl", 16'(5 + c), CAS_WRITE_LATENCY_OUT);
    end
    for (int i = 0; i < 4; i++) begin
      ctl.mrs(3'h1, 16'(i) << 3);
      chk("wl", 16'(al[i] + 12), WRITE_LATENCY_OUT);
      chk("rl", 16'(al[i] + 9), READ_LATENCY_OUT);
    end
  endtask
  task automatic t_fields;
    ctl.mrs(3'h2, 16'h0685);
    chk("rttwr", 3, RTT_WR_OUT);
    chk("srt", 1, SR_RATE_2X_OUT);
    @(posedge REF_CLK_IN) RD_IDX_IN <= 2'h2;
    tick(2);
    chk("word", 16'h0685, RD_DATA_OUT);
    ctl.mrs(3'h0, 16'h0000);
    ctl.mrs(3'h4, 16'h0000);
    chk("partial_array_self_refresh", 5, PARTIAL_ARRAY_SELF_REFRESH_OUT);
    @(posedge REF_CLK_IN) SELF_REFRESH_IN <= 1'b1;
    tick(4);
    chk("retain", 0, RETAIN_ALL_OUT);
    @(posedge REF_CLK_IN) SELF_REFRESH_IN <= 1'b0;
  endtask
  task automatic t_odt;
    ctl.mrs(3'h1, 16'h0000);
    WRITE_ACTIVE_IN <= 1'b1;
    tick(4);
    chk("rtt", 3, ACTIVE_RTT_OUT);
    ctl.mrs(3'h1, 16'h0084);
    chk("dyn", 0, DYN_ODT_EN_OUT);
    chk("rtt", 1, ACTIVE_RTT_OUT);
    chk("wlvl", 1, WRITE_LEVELING_OUT);
    chk("rttnom", 1, RTT_NOM_OUT);
    WRITE_ACTIVE_IN <= 1'b0;
  endtask
  task automatic t_mpr;
    ctl.mrs(3'h3, 16'h0003);
    chk("mprloc", 0, MPR_LOC_OUT);
    ctl.mrs(3'h3, 16'h0006);
    chk("mpren", 1, MPR_EN_OUT);
    chk("mprloc", 2, MPR_LOC_OUT);
  endtask
  initial begin
    tick(16);
    RSTN_IN <= 1'b1;
    tick(3);
    t_strobe();
    t_latency();
    t_fields();
    t_odt();
    t_mpr();
    complete_run();
  end
endmodule // testbench
